// ### inc/scpg_pkg.sv
// Purpose: Constants shared by the safety CRC, parity and guard block.
// Assumes: 20-bit byte addresses, register port 16 bits wide.
// Notes: Offsets are byte addresses in the CPU address space.
package scpg_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // Register offsets.
  localparam logic [19:0] OFS_GUARD_CTL = 20'hf0078;
  localparam logic [19:0] OFS_PARITY_CTL = 20'hf00f5;
  localparam logic [19:0] OFS_CRC_RESULT = 20'hf02fa;
  localparam logic [19:0] OFS_CRC_INPUT = 20'hfffac;

  // Reset values.
  localparam logic [7:0] RST_GUARD_CTL = 8'h00;
  localparam logic [7:0] RST_PARITY_CTL = 8'h00;
  localparam logic [15:0] RST_CRC_RESULT = 16'h0000;
  localparam logic [7:0] RST_CRC_INPUT = 8'h00;

  // Field positions of the access guard control byte.
  localparam int unsigned GC_BAD_ACCESS_EN = 7;
  localparam int unsigned GC_RAM_SIZE_HI = 5;
  localparam int unsigned GC_RAM_SIZE_LO = 4;
  localparam int unsigned GC_PORT_GUARD = 2;
  localparam int unsigned GC_INT_GUARD = 1;
  localparam int unsigned GC_CVP_GUARD = 0;

  // Field positions of the parity control byte.
  localparam int unsigned PC_RESET_MASK = 7;
  localparam int unsigned PC_ERROR_FLAG = 0;

  // Reflected form of x^16 + x^12 + x^5 + 1 for LSB-first shifting.
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  // RAM window; parity covers only these bytes.
  localparam logic [19:0] RAM_START = 20'hff300;
  localparam int unsigned RAM_BYTES = 3072;
  localparam int unsigned RAM_OFS_W = 12;

  // RAM guard region sizes in bytes.
  localparam logic [9:0] GUARD_128 = 10'h080;
  localparam logic [9:0] GUARD_256 = 10'h100;
  localparam logic [9:0] GUARD_512 = 10'h200;
  localparam logic [9:0] GUARD_NONE = 10'h000;

  typedef enum logic [1:0] {
    SCPG_GUARD_OFF = 2'b00,
    SCPG_GUARD_128 = 2'b01,
    SCPG_GUARD_256 = 2'b10,
    SCPG_GUARD_512 = 2'b11
  } scpg_guard_size_t;
endpackage

// ### src/scpg_top.sv
// Purpose: General CRC engine, RAM parity, RAM guard and SFR guard.
// Assumes: One clock; all inputs come from logic on ref_clk.
// Notes: Every output is registered, so forwarded accesses lag one cycle.
//
// Notes on behaviour
// RL1: Byte input register, any value, resets zero.
// RL2: Result updated one clock after input write.
// RL3: Result register word read/write, resets zero.
// RL4: Engine store beats coincident software result write.
// RL5: Software reads result before next input write.
// RL6: Generator polynomial is CCITT x16+x12+x5+1.
// RL7: Input bytes processed least significant bit first.
// RL8: Parity stored per RAM byte, checked on read.
// RL9: Mismatch with mask clear requests system reset.
// RL10: Parity control: mask bit7, flag bit0, zeros.
// RL11: Mask zero enables resets, one disables; default zero.
// RL12: Flag sets on error even while masked.
// RL13: Clearing mask with flag set requests reset.
// RL14: Flag clears only by writing zero or reset.
// RL15: General registers carry no parity.
// RL16: Software initialises RAM before reading it.
// RL17: Guarded RAM region blocks writes, reads normal.
// RL18: Guard size 00 none, 128, 256, 512 bytes.
// RL19: Guard control byte: size 5:4, guards 2:0.
// RL20: SFR guards block writes to their group.
// RL21: Guard bit zero free, one read-only.
// RL22: Blocked writes dropped silently, no flag.
`timescale 1ns/1ns
`default_nettype none
module scpg_top
  import scpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [19:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  output logic [19:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_wr,
  output logic ram_rd,
  input wire logic [7:0] ram_rdata,
  input wire logic [19:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_in_port_group,
  input wire logic sfr_in_int_group,
  input wire logic sfr_in_cvp_group,
  output logic [19:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out,
  output logic sfr_wr_out,
  output logic parity_error_flag,
  output logic parity_reset_req
);

  // Walks one byte through the reflected polynomial, bit 0 first.
  function automatic logic [15:0] scpg_crc_byte(input logic [15:0] crc,
                                                input logic [7:0] data);
    logic [15:0] r;
    r = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1); // RL6 RL7
    end
    return r;
  endfunction

  // Byte offset into RAM and whether the address lies inside it.
  function automatic logic [RAM_OFS_W:0] scpg_ram_ofs(input logic [19:0] a);
    logic [19:0] d;
    d = a - RAM_START;
    return {(a >= RAM_START) && (d < 20'(RAM_BYTES)), d[RAM_OFS_W-1:0]};
  endfunction

  function automatic logic [9:0] scpg_guard_bytes(input logic [1:0] sel);
    logic [9:0] n;
    unique case (scpg_guard_size_t'(sel))
      SCPG_GUARD_OFF: n = GUARD_NONE; // RL18
      SCPG_GUARD_128: n = GUARD_128;
      SCPG_GUARD_256: n = GUARD_256;
      SCPG_GUARD_512: n = GUARD_512;
    endcase
    return n;
  endfunction

  // Register state.
  logic [7:0] crc_in_q;
  logic crc_go_q;
  logic [15:0] crc_res_q;
  logic bad_access_en_q;
  logic [1:0] ram_guard_size_q;
  logic port_guard_q;
  logic int_guard_q;
  logic cvp_guard_q;
  logic mask_q;
  logic flag_q;
  logic reset_req_q;
  logic [15:0] reg_rdata_q;

  // Access path state.
  logic par_mem_q [RAM_BYTES];
  logic [19:0] ram_addr_q;
  logic [7:0] ram_wdata_q;
  logic ram_wr_q;
  logic ram_rd_q;
  logic chk1_q;
  logic chk2_q;
  logic exp1_q;
  logic exp2_q;
  logic [7:0] mem_rdata_q;
  logic mem_rvalid_q;
  logic mem_rd_d1_q;
  logic mem_rd_d2_q;
  logic [19:0] sfr_addr_q;
  logic [7:0] sfr_wdata_q;
  logic sfr_wr_q;

  // Decodes.
  logic wr_crc_in;
  logic wr_crc_res;
  logic wr_guard;
  logic wr_parity;
  logic [RAM_OFS_W:0] wr_ofs;
  logic [RAM_OFS_W:0] rd_ofs;
  logic wr_in_guard;
  logic perr;
  logic sfr_blocked;

  assign wr_crc_in = reg_wr && (reg_addr == OFS_CRC_INPUT);
  assign wr_crc_res = reg_wr && (reg_addr == OFS_CRC_RESULT);
  assign wr_guard = reg_wr && (reg_addr == OFS_GUARD_CTL);
  // The parity control byte belongs to the clock/voltage/parity group.
  assign wr_parity = reg_wr && (reg_addr == OFS_PARITY_CTL) &&
                     !cvp_guard_q; // RL20 RL21
  assign wr_ofs = scpg_ram_ofs(mem_addr);
  assign rd_ofs = scpg_ram_ofs(mem_addr);
  assign wr_in_guard = wr_ofs[RAM_OFS_W] &&
    ({1'b0, wr_ofs[RAM_OFS_W-1:0]} <
     {3'b000, scpg_guard_bytes(ram_guard_size_q)}); // RL17 RL18
  assign perr = chk2_q && ((^ram_rdata) != exp2_q); // RL8
  assign sfr_blocked = (sfr_in_port_group && port_guard_q) ||
                       (sfr_in_int_group && int_guard_q) ||
                       (sfr_in_cvp_group && cvp_guard_q); // RL20 RL21

  // General CRC input byte.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      crc_in_q <= RST_CRC_INPUT;
      crc_go_q <= 1'b0;
    end else begin
      crc_go_q <= wr_crc_in;
      if (wr_crc_in) begin
        crc_in_q <= reg_wdata[7:0]; // RL1
      end
    end
  end

  // General CRC result; software reads it before the next input byte.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      crc_res_q <= RST_CRC_RESULT; // RL3
    end else if (crc_go_q) begin
      crc_res_q <= scpg_crc_byte(crc_res_q, crc_in_q); // RL2 RL4
    end else if (wr_crc_res) begin
      crc_res_q <= reg_wdata; // RL3
    end
  end

  // Access guard control byte; the detect enable can only be set.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bad_access_en_q <= RST_GUARD_CTL[GC_BAD_ACCESS_EN];
      ram_guard_size_q <= RST_GUARD_CTL[GC_RAM_SIZE_HI:GC_RAM_SIZE_LO];
      port_guard_q <= RST_GUARD_CTL[GC_PORT_GUARD];
      int_guard_q <= RST_GUARD_CTL[GC_INT_GUARD];
      cvp_guard_q <= RST_GUARD_CTL[GC_CVP_GUARD];
    end else if (wr_guard) begin
      bad_access_en_q <= bad_access_en_q | reg_wdata[GC_BAD_ACCESS_EN];
      ram_guard_size_q <= reg_wdata[GC_RAM_SIZE_HI:GC_RAM_SIZE_LO]; // RL19
      port_guard_q <= reg_wdata[GC_PORT_GUARD]; // RL19
      int_guard_q <= reg_wdata[GC_INT_GUARD];
      cvp_guard_q <= reg_wdata[GC_CVP_GUARD];
    end
  end

  // Parity reset mask.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_q <= RST_PARITY_CTL[PC_RESET_MASK]; // RL10 RL11
    end else if (wr_parity) begin
      mask_q <= reg_wdata[PC_RESET_MASK]; // RL11
    end
  end

  // Parity error flag: a detected error wins over a clearing write.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_q <= RST_PARITY_CTL[PC_ERROR_FLAG]; // RL10
    end else if (perr) begin
      flag_q <= 1'b1; // RL12
    end else if (wr_parity && !reg_wdata[PC_ERROR_FLAG]) begin
      flag_q <= 1'b0; // RL14
    end
  end

  // Reset request, one cycle long.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= (perr && !mask_q) || // RL9 RL11
        (wr_parity && mask_q && !reg_wdata[PC_RESET_MASK] &&
         (flag_q || perr)); // RL13
    end
  end

  // Register read port; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CRC_INPUT: reg_rdata_q <= {8'h00, crc_in_q};
        OFS_CRC_RESULT: reg_rdata_q <= crc_res_q;
        OFS_GUARD_CTL: reg_rdata_q <= {8'h00, bad_access_en_q, 1'b0,
          ram_guard_size_q, 1'b0, port_guard_q, int_guard_q, cvp_guard_q};
        OFS_PARITY_CTL: reg_rdata_q <= {8'h00, mask_q, 6'h00, flag_q}; // RL10
        default: reg_rdata_q <= 16'h0000;
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  // Parity bits, one per RAM byte; a memory, so no reset.
  always_ff @(posedge ref_clk) begin
    if (mem_wr && wr_ofs[RAM_OFS_W] && !wr_in_guard) begin
      par_mem_q[wr_ofs[RAM_OFS_W-1:0]] <= ^mem_wdata; // RL8
    end
  end

  // Forward RAM accesses; a guarded write simply never reaches the RAM.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ram_addr_q <= 20'h00000;
      ram_wdata_q <= 8'h00;
      ram_wr_q <= 1'b0;
      ram_rd_q <= 1'b0;
    end else begin
      ram_addr_q <= mem_addr;
      ram_wdata_q <= mem_wdata;
      ram_wr_q <= mem_wr && !wr_in_guard; // RL17 RL22
      ram_rd_q <= mem_rd; // RL17
    end
  end

  // Parity check pipeline: RAM answers the cycle after ram_rd.
  // Addresses outside the RAM window, such as the general registers,
  // are never checked.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chk1_q <= 1'b0;
      chk2_q <= 1'b0;
      exp1_q <= 1'b0;
      exp2_q <= 1'b0;
    end else begin
      chk1_q <= mem_rd && rd_ofs[RAM_OFS_W]; // RL15
      exp1_q <= par_mem_q[rd_ofs[RAM_OFS_W-1:0]];
      chk2_q <= chk1_q;
      exp2_q <= exp1_q;
    end
  end

  // Read data back to the CPU side.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_rdata_q <= 8'h00;
      mem_rvalid_q <= 1'b0;
    end else begin
      mem_rvalid_q <= chk2_q || (mem_rd_d2_q && !chk2_q);
      mem_rdata_q <= ram_rdata;
    end
  end

  // Tracks reads outside the RAM window so they still return data.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_rd_d1_q <= 1'b0;
      mem_rd_d2_q <= 1'b0;
    end else begin
      mem_rd_d1_q <= mem_rd;
      mem_rd_d2_q <= mem_rd_d1_q;
    end
  end

  // SFR write gate; a blocked write is dropped with no trace.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_addr_q <= 20'h00000;
      sfr_wdata_q <= 8'h00;
      sfr_wr_q <= 1'b0;
    end else begin
      sfr_addr_q <= sfr_addr;
      sfr_wdata_q <= sfr_wdata;
      sfr_wr_q <= sfr_wr && !sfr_blocked; // RL20 RL22
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign mem_rdata = mem_rdata_q;
  assign mem_rvalid = mem_rvalid_q;
  assign ram_addr = ram_addr_q;
  assign ram_wdata = ram_wdata_q;
  assign ram_wr = ram_wr_q;
  assign ram_rd = ram_rd_q;
  assign sfr_addr_out = sfr_addr_q;
  assign sfr_wdata_out = sfr_wdata_q;
  assign sfr_wr_out = sfr_wr_q;
  assign parity_error_flag = flag_q;
  assign parity_reset_req = reset_req_q;

endmodule
`default_nettype wire

// ### tb/scpg_props.sv
// Purpose: Port-level checks of the safety CRC, parity and guard block.
// Assumes: One clock, synchronous active-low reset.
// Notes: The guard byte is mirrored from register writes at the port.
`timescale 1ns/1ns
`default_nettype none
module scpg_props
  import scpg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [19:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [19:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_wr,
  input wire logic ram_rd,
  input wire logic [7:0] ram_rdata,
  input wire logic [19:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_in_port_group,
  input wire logic sfr_in_int_group,
  input wire logic sfr_in_cvp_group,
  input wire logic [19:0] sfr_addr_out,
  input wire logic sfr_wr_out,
  input wire logic parity_error_flag,
  input wire logic parity_reset_req
);
  logic [7:0] guard_q;
  logic [10:0] lim;
  logic [19:0] ofs;
  logic ram_blk;
  logic sfr_blk;
  logic pctl_wr;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      guard_q <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_GUARD_CTL) begin
      guard_q <= reg_wdata[7:0];
    end
  end
  assign lim = (guard_q[5:4] == 2'b00) ? 11'h000 : 11'h040 << guard_q[5:4];
  assign ofs = mem_addr - RAM_START;
  assign ram_blk = (mem_addr >= RAM_START) && (ofs < {9'h000, lim});
  assign sfr_blk = (sfr_in_port_group & guard_q[2]) |
    (sfr_in_int_group & guard_q[1]) | (sfr_in_cvp_group & guard_q[0]);
  assign pctl_wr = reg_wr && reg_addr == OFS_PARITY_CTL;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ram_block_a: assert property (
    mem_wr && ram_blk |=> !ram_wr) else $error("guarded RAM write passed");
  ram_free_a: assert property (
    mem_wr && !ram_blk |=> ram_wr && ram_wdata == $past(mem_wdata))
    else $error("free RAM write lost");
  ram_cause_a: assert property (
    ram_wr |-> $past(mem_wr)) else $error("RAM write without request");
  read_fwd_a: assert property (
    mem_rd |=> ram_rd && ram_addr == $past(mem_addr))
    else $error("RAM read not forwarded");
  read_done_a: assert property (
    ram_rd |-> ##2 mem_rvalid) else $error("read data not returned");
  read_data_a: assert property (
    mem_rvalid |-> mem_rdata == $past(ram_rdata))
    else $error("read data altered");
  sfr_block_a: assert property (
    sfr_wr && sfr_blk |=> !sfr_wr_out) else $error("guarded SFR write passed");
  sfr_free_a: assert property (
    sfr_wr && !sfr_blk |=> sfr_wr_out && sfr_addr_out == $past(sfr_addr))
    else $error("free SFR write lost");
  flag_rise_a: assert property (
    $rose(parity_error_flag) |-> mem_rvalid) else $error("flag set without read");
  flag_hold_a: assert property (
    parity_error_flag && !pctl_wr |=> parity_error_flag)
    else $error("flag cleared without write");
  req_cause_a: assert property (
    parity_reset_req |-> mem_rvalid || $past(pctl_wr))
    else $error("reset request without cause");
endmodule
bind scpg_top scpg_props scpg_props_inst (.ref_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
  .mem_rvalid, .ram_addr, .ram_wdata, .ram_wr, .ram_rd, .ram_rdata,
  .sfr_addr, .sfr_wr, .sfr_in_port_group, .sfr_in_int_group,
  .sfr_in_cvp_group, .sfr_addr_out, .sfr_wr_out, .parity_error_flag,
  .parity_reset_req);
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the safety CRC, parity and guard block.
// Assumes: The bench stands in for the CPU, the RAM array and the SFR bus.
// Notes: The RAM model flips bit 0 on demand to fake a parity fault.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import scpg_pkg::*;
;
  typedef struct {logic [19:0] a; logic [15:0] w; logic [15:0] e;} scpg_row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, flip = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
  logic sfr_wr = 1'b0, sfr_in_port_group = 1'b0, sfr_in_int_group = 1'b0;
  logic sfr_in_cvp_group = 1'b0, mem_rvalid, ram_wr, ram_rd, sfr_wr_out;
  logic parity_error_flag, parity_reset_req;
  logic [19:0] reg_addr = 20'h0, mem_addr = 20'h0, sfr_addr = 20'h0;
  logic [19:0] ram_addr, sfr_addr_out;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, crc;
  logic [7:0] mem_wdata = 8'h0, sfr_wdata = 8'h0, ram_rdata = 8'h0;
  logic [7:0] mem_rdata, ram_wdata, sfr_wdata_out;
  logic [7:0] ram_m [4096];
  logic [7:0] bytes [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
  logic [10:0] sz [4] = '{11'h000, 11'h080, 11'h100, 11'h200};
  scpg_row_t rows [5] = '{'{OFS_PARITY_CTL, 16'h00fe, 16'h0080},
    '{OFS_CRC_INPUT, 16'h00a5, 16'h00a5}, '{OFS_CRC_RESULT, 16'hbeef, 16'hbeef},
    '{OFS_GUARD_CTL, 16'h0037, 16'h0037}, '{20'hf0000, 16'hffff, 16'h0000}};
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  scpg_top scpg_top_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
    .mem_rvalid, .ram_addr, .ram_wdata, .ram_wr, .ram_rd, .ram_rdata,
    .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_in_port_group, .sfr_in_int_group,
    .sfr_in_cvp_group, .sfr_addr_out, .sfr_wdata_out, .sfr_wr_out,
    .parity_error_flag, .parity_reset_req);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Unread cycles show inverted data, so a late sample cannot pass by luck.
  always @(posedge ref_clk) begin
    if (ram_wr) ram_m[ram_addr[11:0]] <= ram_wdata;
    ram_rdata <= ram_rd ? ram_m[ram_addr[11:0]] ^ {7'h00, flip} : ~ram_rdata;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] crc_ref(input logic [15:0] c,
    input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    return c;
  endfunction
  // Every bus task starts in the time step of a rising edge and ends in one.
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // The second write follows with no gap, so it meets the store edge.
  task automatic wr2(input logic [19:0] a, input logic [15:0] d,
    input logic [19:0] b, input logic [15:0] f);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_addr <= b;
    reg_wdata <= f;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
    @(posedge ref_clk);
  endtask
  task automatic mwr(input logic [19:0] a, input logic [7:0] d, input logic e);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge ref_clk);
    mem_wr <= 1'b0;
    @(negedge ref_clk);
    chk("ram_wr", {15'h0, e}, {15'h0, ram_wr});
    @(posedge ref_clk);
  endtask
  task automatic mrd(input logic [19:0] a, input logic [7:0] e,
    input logic f, input logic q);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge ref_clk);
    mem_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("rvalid flag req data", {1'b1, f, q, 5'h00, e},
      {mem_rvalid, parity_error_flag, parity_reset_req, 5'h00, mem_rdata});
    @(posedge ref_clk);
  endtask
  task automatic swr(input logic [2:0] g, input logic e);
    {sfr_in_port_group, sfr_in_int_group, sfr_in_cvp_group} <= g;
    sfr_addr <= 20'hf0030;
    sfr_wdata <= 8'h5a;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(negedge ref_clk);
    chk("sfr_wr_out sfr_wdata_out", {7'h00, e, 8'h5a},
      {7'h00, sfr_wr_out, sfr_wdata_out});
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_GUARD_CTL, {8'h00, RST_GUARD_CTL});
    rd(OFS_PARITY_CTL, {8'h00, RST_PARITY_CTL});
    rd(OFS_CRC_RESULT, RST_CRC_RESULT);
    rd(OFS_CRC_INPUT, {8'h00, RST_CRC_INPUT});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    wr(OFS_GUARD_CTL, 16'h0000);
    wr(OFS_PARITY_CTL, 16'h0000);
    wr(OFS_CRC_RESULT, 16'h0000);
    crc = 16'h0000;
    // The result write lands in the engine's store cycle and must be lost.
    foreach (bytes[i]) begin
      crc = crc_ref(crc, bytes[i]);
      wr2(OFS_CRC_INPUT, {8'h00, bytes[i]}, OFS_CRC_RESULT, 16'hffff);
      rd(OFS_CRC_RESULT, crc);
    end
    rd(OFS_CRC_RESULT, 16'h08f6);
    mwr(RAM_START, 8'h3c, 1'b1);
    mrd(RAM_START, 8'h3c, 1'b0, 1'b0);
    flip <= 1'b1;
    mrd(RAM_START, 8'h3d, 1'b1, 1'b1);
    flip <= 1'b0;
    mrd(RAM_START, 8'h3c, 1'b1, 1'b0);
    wr(OFS_PARITY_CTL, 16'h0080);
    rd(OFS_PARITY_CTL, 16'h0080);
    flip <= 1'b1;
    mrd(RAM_START, 8'h3d, 1'b1, 1'b0);
    flip <= 1'b0;
    // The request pulse stands one cycle only, so it is looked at inline.
    reg_addr <= OFS_PARITY_CTL;
    reg_wdata <= 16'h0001;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
    chk("parity_reset_req", 16'h0001, {15'h0, parity_reset_req});
    @(posedge ref_clk);
    wr(OFS_PARITY_CTL, 16'h0000);
    rd(OFS_PARITY_CTL, 16'h0000);
    // A byte above the RAM window carries no parity, so a fault passes.
    mwr(20'hfff10, 8'h77, 1'b1);
    flip <= 1'b1;
    mrd(20'hfff10, 8'h76, 1'b0, 1'b0);
    flip <= 1'b0;
    wr(OFS_GUARD_CTL, 16'h0001);
    wr(OFS_PARITY_CTL, 16'h0080);
    rd(OFS_PARITY_CTL, 16'h0000);
    // The last guarded byte is first written freely, then blocked.
    for (int g = 0; g < 4; g++) begin
      wr(OFS_GUARD_CTL, 16'(g << 4));
      mwr(RAM_START + {9'h0, sz[(g == 0) ? 3 : g] - 11'h1},
        (g == 0) ? 8'ha5 : 8'hc3, g == 0);
      mwr(RAM_START + {9'h0, sz[g]}, 8'h5a, 1'b1);
    end
    mrd(RAM_START + 20'h001ff, 8'ha5, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        wr(OFS_GUARD_CTL, 16'(1 << i));
        swr(3'(1 << j), i != j);
      end
    end
    flip <= 1'b1;
    mrd(RAM_START, 8'h5b, 1'b1, 1'b1);
    flip <= 1'b0;
    // A reset in mid-run must clear the flag and the result again.
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("parity_error_flag", 16'h0000, {15'h0, parity_error_flag});
    @(posedge ref_clk);
    rd(OFS_CRC_RESULT, RST_CRC_RESULT);
    summarize();
  end
endmodule
`default_nettype wire
